// ===== core/pmsr_defines.svh
/*
 * Offsets, field positions, reset values and fixed figures of the
 * status read-back block. Assumes inclusion by bare name.
 */
`ifndef PMSR_DEFINES_SVH
`define PMSR_DEFINES_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMSR_OFF_TEMP 8'h7d
`define PMSR_OFF_COMM 8'h7e
`define PMSR_OFF_VEND 8'h80
`define PMSR_OFF_VOUT 8'h8b

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMSR_TEMP_FAULT_BIT 7
`define PMSR_TEMP_WARN_BIT 6
`define PMSR_COMM_BADCMD_BIT 7
`define PMSR_COMM_BADDATA_BIT 6
`define PMSR_COMM_PEC_BIT 5
`define PMSR_COMM_MEM_BIT 4
`define PMSR_COMM_OTHER_BIT 1
`define PMSR_VEND_DIE_BIT 7
`define PMSR_VEND_ZERO_BIT 6
`define PMSR_VEND_MULTI_BIT 5
`define PMSR_VEND_VSTRAP_BIT 4
`define PMSR_VEND_SSTRAP_BIT 3

// ----------------------------------------------------------------
// clear masks, alert eligibility, reset values
// ----------------------------------------------------------------
`define PMSR_TEMP_W1C 8'hc0
`define PMSR_COMM_W1C 8'hf2
`define PMSR_VEND_W1C 8'h98
`define PMSR_TEMP_ALERT 8'hc0
`define PMSR_COMM_ALERT 8'hf2
`define PMSR_VEND_ALERT 8'h90
`define PMSR_BYTE_RST 8'h00
`define PMSR_WORD_RST 16'h0000

// ----------------------------------------------------------------
// fixed figures
// ----------------------------------------------------------------
`define PMSR_TEMP_HYST 20
`define PMSR_VOUT_EXP 5'b10111
`define PMSR_STRAP_RUN 4

`endif

// ===== core/pmsr_pkg.sv
/*
 * Types shared by the status read-back block.
 * Assumes the defines header is compiled alongside.
 */
package pmsr_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef logic [7:0] pmsr_byte_t;
	typedef logic [15:0] pmsr_word_t;
	typedef enum logic [1:0] {
		PMSR_SEL_TEMP = 2'b00,
		PMSR_SEL_COMM = 2'b01,
		PMSR_SEL_VEND = 2'b10,
		PMSR_SEL_VOUT = 2'b11
	} pmsr_sel_t;

endpackage

// ===== core/pmsr_status_readback.sv
/*
 * Status and output-voltage read-back of a power converter's
 * management interface: temperature, communication and vendor status
 * bytes plus the output voltage word, addressed by command code.
 * Assumes a protocol engine on the same clock that hands over decoded
 * command codes and event pulses, and an analog front end that
 * supplies readings already in this clock's domain.
 */
`include "pmsr_defines.svh"

module pmsr_status_readback #(
	parameter int TW = 11,
	parameter int FW = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] cmdCode,
	input wire logic rdReq,
	input wire logic wrReq,
	input wire pmsr_pkg::pmsr_byte_t wrData,
	input wire logic clearFaults,
	input wire logic badCmdEvt,
	input wire logic badDataEvt,
	input wire logic pecFailEvt,
	input wire logic memFaultEvt,
	input wire logic otherCommEvt,
	input wire logic signed [TW-1:0] tempReading,
	input wire logic signed [TW-1:0] overtempFaultThreshold,
	input wire logic signed [TW-1:0] overtempWarnThreshold,
	input wire logic dieShutdownEvt,
	input wire logic [FW-1:0] opState,
	input wire logic [1:0] strapStb,
	input wire logic [1:0][3:0] strapCode,
	input wire logic [1:0] strapEnd,
	input wire logic startDespiteStrapFail,
	input wire logic loopFollower,
	input wire logic resetPgdPin,
	input wire logic syncFault,
	input wire logic [10:0] voutMantissa,
	input wire pmsr_pkg::pmsr_byte_t tempAlertMask,
	input wire pmsr_pkg::pmsr_byte_t commAlertMask,
	input wire pmsr_pkg::pmsr_byte_t vendAlertMask,
	output pmsr_pkg::pmsr_word_t rdData,
	output logic rdAck,
	output logic alert,
	output logic vendorSummary,
	output logic loopMasterEn
);
	import pmsr_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	localparam logic signed [TW:0] HYST = (TW+1)'(`PMSR_TEMP_HYST);
	localparam logic [2:0] RUN = 3'(`PMSR_STRAP_RUN);

	// command code to register select, with hit flag
	function automatic logic [2:0] decode(input logic [7:0] c);
		case (c)
			`PMSR_OFF_TEMP: decode = {1'b1, PMSR_SEL_TEMP};
			`PMSR_OFF_COMM: decode = {1'b1, PMSR_SEL_COMM};
			`PMSR_OFF_VEND: decode = {1'b1, PMSR_SEL_VEND};
			`PMSR_OFF_VOUT: decode = {1'b1, PMSR_SEL_VOUT};
			default: decode = 3'b000;
		endcase
	endfunction

	// latched flag update: the set wins over a same-cycle clear
	function automatic pmsr_byte_t latch(input pmsr_byte_t cur,
		input pmsr_byte_t set, input pmsr_byte_t clr);
		latch = (cur & ~clr) | set;
	endfunction

	// write-one-clear bits for a register, plus clear-faults
	function automatic pmsr_byte_t clrOf(input pmsr_sel_t s,
		input pmsr_byte_t w1c);
		logic [2:0] d;
		d = decode(cmdCode);
		clrOf = 8'h00;
		if (clearFaults)
			clrOf = w1c;
		if (wrReq && d[2] && pmsr_sel_t'(d[1:0]) == s)
			clrOf = clrOf | (wrData & w1c);
	endfunction

	pmsr_byte_t tempStatus;
	pmsr_byte_t commStatus;
	pmsr_byte_t vendLatch;
	logic [2:0] vendLive;
	pmsr_byte_t vendorStatus;
	logic [1:0] hot;
	logic [1:0] strapFail;
	logic pgdMeta;
	logic pgdSync;
	logic stateZero;
	logic stateMulti;
	logic [2:0] rdSel;
	pmsr_byte_t commSet;
	pmsr_byte_t vendSet;
	pmsr_byte_t vendClr;

	assign vendorStatus = {vendLatch[7:3], vendLive};
	assign stateZero = (opState == '0);
	assign stateMulti = ($countones(opState) > 1);
	assign rdSel = decode(cmdCode);

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	// reset/power-good pin is asynchronous to clk
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pgdMeta <= 1'b1;
			pgdSync <= 1'b1;
		end else begin
			pgdMeta <= resetPgdPin;
			pgdSync <= pgdMeta;
		end
	end

	// ------------------------------------------------------------
	// temperature hysteresis
	// ------------------------------------------------------------
	// index 1 = fault threshold, index 0 = warning threshold
	generate
		for (genvar g = 0; g < 2; g++) begin : g_hot
			logic signed [TW:0] th;
			logic signed [TW:0] tr;
			assign th = (g == 1) ?
				(TW+1)'(overtempFaultThreshold) :
				(TW+1)'(overtempWarnThreshold);
			assign tr = (TW+1)'(tempReading);
			// stays hot until 20 degrees below, so a clear re-sets
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b)
					hot[g] <= 1'b0;
				else if (tr >= th)
					hot[g] <= 1'b1;
				else if (tr <= th - HYST)
					hot[g] <= 1'b0;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// strap detection
	// ------------------------------------------------------------
	// index 1 = boot voltage strap, index 0 = soft-start strap
	generate
		for (genvar s = 0; s < 2; s++) begin : g_strap
			logic [3:0] lastCode;
			logic [2:0] runCnt;
			// counts consecutive equal samples, saturating at the goal
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					lastCode <= 4'h0;
					runCnt <= 3'd0;
				end else if (strapEnd[s]) begin
					runCnt <= 3'd0;
				end else if (strapStb[s]) begin
					lastCode <= strapCode[s];
					if (runCnt != 3'd0 && strapCode[s] == lastCode)
						runCnt <= (runCnt >= RUN) ? RUN : runCnt + 3'd1;
					else
						runCnt <= 3'd1;
				end
			end
			// a window that ends unresolved is a failure
			assign strapFail[s] = strapEnd[s] && (runCnt < RUN);
		end
	endgenerate

	// ------------------------------------------------------------
	// status registers
	// ------------------------------------------------------------
	// temperature byte; bits 5..0 never set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			tempStatus <= `PMSR_BYTE_RST;
		else
			tempStatus <= latch(tempStatus, {hot, 6'h00},
				clrOf(PMSR_SEL_TEMP, `PMSR_TEMP_W1C));
	end

	// communication set pulses; bits 3, 2, 0 never set
	always_comb begin
		commSet = 8'h00;
		commSet[`PMSR_COMM_BADCMD_BIT] = badCmdEvt;
		commSet[`PMSR_COMM_BADDATA_BIT] = badDataEvt;
		commSet[`PMSR_COMM_PEC_BIT] = pecFailEvt;
		commSet[`PMSR_COMM_MEM_BIT] = memFaultEvt;
		commSet[`PMSR_COMM_OTHER_BIT] = otherCommEvt;
	end

	// communication byte
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			commStatus <= `PMSR_BYTE_RST;
		else
			commStatus <= latch(commStatus, commSet,
				clrOf(PMSR_SEL_COMM, `PMSR_COMM_W1C));
	end

	// vendor set and clear; fsm flags clear only by clear-faults,
	// strap flags ignore on/off events entirely
	always_comb begin
		vendSet = 8'h00;
		vendSet[`PMSR_VEND_DIE_BIT] = dieShutdownEvt;
		vendSet[`PMSR_VEND_ZERO_BIT] = stateZero;
		vendSet[`PMSR_VEND_MULTI_BIT] = stateMulti;
		vendSet[`PMSR_VEND_VSTRAP_BIT] = strapFail[1];
		vendSet[`PMSR_VEND_SSTRAP_BIT] = strapFail[0];
		vendClr = clrOf(PMSR_SEL_VEND, `PMSR_VEND_W1C);
		if (clearFaults)
			vendClr = vendClr | 8'he0;
	end

	// vendor latched bits; a follower holds both strap flags at zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			vendLatch <= `PMSR_BYTE_RST;
		else if (loopFollower)
			vendLatch <= latch(vendLatch, vendSet, vendClr) & 8'he7;
		else
			vendLatch <= latch(vendLatch, vendSet, vendClr);
	end

	// vendor live bits, never latched
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			vendLive <= 3'b000;
		else
			vendLive <= {!pgdSync, loopFollower, syncFault};
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// one-cycle answer; unmapped codes answer zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData <= `PMSR_WORD_RST;
			rdAck <= 1'b0;
		end else begin
			rdAck <= rdReq;
			if (rdReq) begin
				case (rdSel)
					{1'b1, PMSR_SEL_TEMP}: rdData <= {8'h00, tempStatus};
					{1'b1, PMSR_SEL_COMM}: rdData <= {8'h00, commStatus};
					{1'b1, PMSR_SEL_VEND}: rdData <= {8'h00, vendorStatus};
					{1'b1, PMSR_SEL_VOUT}:
						rdData <= {`PMSR_VOUT_EXP, voutMantissa};
					default: rdData <= `PMSR_WORD_RST;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// alert, summary, loop enable
	// ------------------------------------------------------------
	// only eligible, unmasked latched bits reach the alert line
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alert <= 1'b0;
			vendorSummary <= 1'b0;
			loopMasterEn <= 1'b0;
		end else begin
			alert <= |(tempStatus & `PMSR_TEMP_ALERT & ~tempAlertMask)
				|| |(commStatus & `PMSR_COMM_ALERT & ~commAlertMask)
				|| |(vendLatch & `PMSR_VEND_ALERT & ~vendAlertMask);
			vendorSummary <= |vendLatch[7:3];
			// start is held off while the voltage strap failure is latched, unless startDespiteStrapFail
			loopMasterEn <= !vendLatch[`PMSR_VEND_VSTRAP_BIT]
				|| startDespiteStrapFail;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence commClear5;
		wrReq && cmdCode == `PMSR_OFF_COMM && wrData[5];
	endsequence

	sequence voutRead;
		rdReq && cmdCode == `PMSR_OFF_VOUT;
	endsequence

	temp_fault_set_a: assert property (
		tempReading >= overtempFaultThreshold |=> ##1 tempStatus[7])
		else $error("fault temperature did not set bit 7");

	temp_rearm_a: assert property (
		hot[0] && tempReading < overtempWarnThreshold &&
		(TW+1)'(tempReading) > (TW+1)'(overtempWarnThreshold) - HYST
		|=> hot[0] ##1 tempStatus[6])
		else $error("warning bit dropped inside hysteresis band");

	w1c_clear_a: assert property (
		commClear5 and (!pecFailEvt) |=> !commStatus[5])
		else $error("written one did not clear pec bit");

	set_wins_a: assert property (
		commClear5 and pecFailEvt |=> commStatus[5])
		else $error("clear beat a same-cycle pec event");

	comm_badcmd_a: assert property (
		badCmdEvt |=> commStatus[7] && commStatus[3:2] == 2'b00)
		else $error("bad command event lost");

	fsm_zero_a: assert property (
		stateZero |=> vendorStatus[6])
		else $error("zero fsm state not flagged");

	multi_hot_a: assert property (
		stateMulti |=> vendorStatus[5])
		else $error("multi-hot fsm state not flagged");

	follower_force_a: assert property (
		loopFollower |=> vendorStatus[4:3] == 2'b00 && vendorStatus[1])
		else $error("follower strap flags not forced low");

	info_no_alert_a: assert property (
		tempStatus == 8'h00 && commStatus == 8'h00 &&
		!vendLatch[7] && !vendLatch[4] |=> !alert)
		else $error("informational bit raised alert");

	alert_raise_a: assert property (
		tempStatus[7] && !tempAlertMask[7] |=> alert)
		else $error("unmasked fault did not raise alert");

	vout_read_a: assert property (
		voutRead |=> rdAck &&
		rdData == {`PMSR_VOUT_EXP, $past(voutMantissa)})
		else $error("voltage read word wrong");

	strap_block_a: assert property (
		strapFail[1] && !loopFollower && !startDespiteStrapFail
		|=> ##1 !loopMasterEn)
		else $error("loop master not held off after strap failure");

	summary_a: assert property (
		vendLatch[7:3] != 5'b0 |=> vendorSummary)
		else $error("vendor summary not set");

endmodule // pmsr_status_readback

// ===== sim/pmsr_host_model.sv
/*
 * Host side of the management link: register reads, one-clears and
 * the clear-faults command. Assumes the bench calls its tasks and
 * shares its clock; requests change 1 ns after a rising edge.
 */
module pmsr_host_model (
	input wire logic clk,
	input wire pmsr_pkg::pmsr_word_t rdData,
	input wire logic rdAck,
	output logic [7:0] cmdCode,
	output logic rdReq,
	output logic wrReq,
	output pmsr_pkg::pmsr_byte_t wrData,
	output logic clearFaults
);
	timeunit 1ns;
	timeprecision 100ps;
	import pmsr_pkg::*;

	// idle values at time zero
	initial begin
		cmdCode = 8'h00;
		rdReq = 1'b0;
		wrReq = 1'b0;
		wrData = 8'h00;
		clearFaults = 1'b0;
	end

	// one-cycle read; a missing acknowledge yields unknown data
	task automatic rd(input logic [7:0] code, output pmsr_word_t data);
		@(posedge clk);
		#1;
		cmdCode = code;
		rdReq = 1'b1;
		@(posedge clk);
		#1;
		rdReq = 1'b0;
		cmdCode = ~code; // stale code is the complement, never the code just used
		data = (rdAck === 1'b1) ? rdData : 16'hxxxx;
	endtask

	// ones in the byte clear the matching write-one-clear status bits
	task automatic wr(input logic [7:0] code, input pmsr_byte_t data);
		@(posedge clk);
		#1;
		cmdCode = code;
		wrData = data;
		wrReq = 1'b1;
		@(posedge clk);
		#1;
		wrReq = 1'b0;
		cmdCode = ~code;
		wrData = ~data;
	endtask

	// clear-faults command pulse
	task automatic clr;
		@(posedge clk);
		#1;
		clearFaults = 1'b1;
		@(posedge clk);
		#1;
		clearFaults = 1'b0;
	endtask
endmodule // pmsr_host_model

// ===== sim/pmsr_status_readback_tb_top.sv
/*
 * Self-checking bench of the status read-back block.
 * Assumes the design package, defines header and host model compiled.
 */
`include "pmsr_defines.svh"
module pmsr_status_readback_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import pmsr_pkg::*;

	logic clk = 1'b0, rst_b = 1'b0, rdReq, wrReq, clearFaults, rdAck;
	logic [7:0] cmdCode;
	pmsr_byte_t wrData;
	pmsr_word_t rdData, d;
	logic [4:0] evt = '0;
	logic signed [10:0] temp = 0, fth = 100, wth = 80;
	logic die = 0, ovr = 0, fol = 0, pgd = 1, sync = 0;
	logic [7:0] op = 8'h01;
	logic [1:0] stb = '0, stEnd = '0;
	logic [1:0][3:0] sCode = '0;
	logic [10:0] mant = '0;
	pmsr_byte_t tMask = '0, cMask = '0, vMask = '0;
	logic alert, vSum, lmEn;
	int checks = 0, badCount = 0;
	int bp[5] = '{7, 6, 5, 4, 1};

	always #5 clk = ~clk;

	pmsr_host_model host (.clk(clk), .rdData(rdData), .rdAck(rdAck),
		.cmdCode(cmdCode), .rdReq(rdReq), .wrReq(wrReq), .wrData(wrData),
		.clearFaults(clearFaults));

	pmsr_status_readback uut (.clk(clk), .rst_b(rst_b), .cmdCode(cmdCode),
		.rdReq(rdReq), .wrReq(wrReq), .wrData(wrData),
		.clearFaults(clearFaults), .badCmdEvt(evt[4]), .badDataEvt(evt[3]),
		.pecFailEvt(evt[2]), .memFaultEvt(evt[1]), .otherCommEvt(evt[0]),
		.tempReading(temp), .overtempFaultThreshold(fth),
		.overtempWarnThreshold(wth), .dieShutdownEvt(die), .opState(op),
		.strapStb(stb), .strapCode(sCode), .strapEnd(stEnd),
		.startDespiteStrapFail(ovr), .loopFollower(fol),
		.resetPgdPin(pgd), .syncFault(sync), .voutMantissa(mant),
		.tempAlertMask(tMask), .commAlertMask(cMask), .vendAlertMask(vMask),
		.rdData(rdData), .rdAck(rdAck), .alert(alert),
		.vendorSummary(vSum), .loopMasterEn(lmEn));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic rdc(input string nm, input logic [7:0] c, logic [15:0] e);
		host.rd(c, d);
		chk(nm, d, e);
	endtask

	// linear word with the fixed exponent of minus nine
	function automatic logic [15:0] vw(input logic [10:0] m);
		return {`PMSR_VOUT_EXP, m};
	endfunction

	// n back-to-back equal samples, then the end-of-detection pulse
	task automatic strap(input int i, input int n);
		sCode[i] = 4'h5;
		if (n > 0) begin
			stb[i] = 1'b1;
			cyc(n);
			stb[i] = 1'b0;
		end
		stEnd[i] = 1'b1;
		cyc(1);
		stEnd[i] = 1'b0;
		cyc(3);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, badCount);
		if (badCount == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// watchdog sized well beyond the few hundred cycles used
	initial begin
		#100000;
		badCount++;
		end_sim;
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hed2a));
		cyc(6);
		rst_b = 1'b1;
		cyc(2);
		rdc("temp", `PMSR_OFF_TEMP, 16'h0000);
		rdc("comm", `PMSR_OFF_COMM, 16'h0000);
		rdc("vend", `PMSR_OFF_VEND, 16'h0000);
		rdc("unmapped", 8'h81, 16'h0000);
		chk("alert", alert, 1'b0);
		chk("master", lmEn, 1'b1);
		$display("test reset done");
		// every communication fault, set then one-cleared
		for (int i = 0; i < 5; i++) begin
			evt = 5'b10000 >> i;
			cyc(1);
			evt = '0;
			cyc(3);
			chk("alert", alert, 1'b1);
			rdc("comm", `PMSR_OFF_COMM, 16'h1 << bp[i]);
			host.wr(`PMSR_OFF_COMM, 8'(($urandom & 8'h0d) | (1 << bp[i])));
			cyc(3);
			rdc("comm", `PMSR_OFF_COMM, 16'h0000);
			chk("alert", alert, 1'b0);
		end
		cMask = 8'hff;
		evt = 5'b00100;
		cyc(1);
		evt = '0;
		cyc(3);
		chk("alert", alert, 1'b0);
		host.clr;
		cyc(2);
		rdc("comm", `PMSR_OFF_COMM, 16'h0000);
		cMask = '0;
		$display("test comm done");
		// warning, hysteresis boundary, then fault
		temp = 85;
		cyc(4);
		rdc("temp", `PMSR_OFF_TEMP, 16'h0040);
		chk("alert", alert, 1'b1);
		temp = 61;
		host.wr(`PMSR_OFF_TEMP, 8'h40);
		cyc(4);
		rdc("temp", `PMSR_OFF_TEMP, 16'h0040);
		temp = 60;
		host.wr(`PMSR_OFF_TEMP, 8'h40);
		cyc(4);
		rdc("temp", `PMSR_OFF_TEMP, 16'h0000);
		temp = 100;
		cyc(4);
		rdc("temp", `PMSR_OFF_TEMP, 16'h00c0);
		temp = 0;
		host.clr;
		cyc(4);
		rdc("temp", `PMSR_OFF_TEMP, 16'h0000);
		$display("test temp done");
		// vendor byte: die, state machine, straps, role, pin, sync
		die = 1'b1;
		cyc(1);
		die = 1'b0;
		cyc(3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0080);
		chk("alert", alert, 1'b1);
		chk("summary", vSum, 1'b1);
		host.wr(`PMSR_OFF_VEND, 8'h80);
		cyc(3);
		chk("summary", vSum, 1'b0);
		op = 8'h00;
		cyc(3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0040);
		op = 8'h03;
		cyc(3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0060);
		chk("alert", alert, 1'b0);
		op = 8'h01;
		host.clr;
		strap(1, 4);
		rdc("vend", `PMSR_OFF_VEND, 16'h0000);
		strap(1, 3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0010);
		chk("master", lmEn, 1'b0);
		chk("alert", alert, 1'b1);
		ovr = 1'b1;
		cyc(3);
		chk("master", lmEn, 1'b1);
		ovr = 1'b0;
		strap(0, 3);
		host.wr(`PMSR_OFF_VEND, 8'h10);
		cyc(3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0008);
		chk("alert", alert, 1'b0);
		host.clr;
		cyc(2);
		rdc("vend", `PMSR_OFF_VEND, 16'h0000);
		fol = 1'b1;
		strap(1, 0);
		strap(0, 0);
		rdc("vend", `PMSR_OFF_VEND, 16'h0002);
		fol = 1'b0;
		pgd = 1'b0;
		cyc(5);
		rdc("vend", `PMSR_OFF_VEND, 16'h0004);
		pgd = 1'b1;
		sync = 1'b1;
		cyc(5);
		rdc("vend", `PMSR_OFF_VEND, 16'h0001);
		chk("alert", alert, 1'b0);
		sync = 1'b0;
		cyc(3);
		rdc("vend", `PMSR_OFF_VEND, 16'h0000);
		$display("test vendor done");
		// all-ones then seven random mantissas through the voltage word
		for (int i = 0; i < 8; i++) begin
			mant = (i == 0) ? 11'h7ff : 11'($urandom);
			cyc(2);
			rdc("vout", `PMSR_OFF_VOUT, vw(mant));
		end
		$display("test vout done");
		end_sim;
	end
endmodule // pmsr_status_readback_tb_top
